// ---- nsf_sequencer.sv ----
/*
  Special-function sequencer of a NAND flash controller: erase, lock,
  transfer mode and read-modify-write, driven by command/data writes.
  Assumes a flash engine behind fl_req that answers each request with
  exactly one fl_rsp.done pulse, and a plain register master.
*/
// Our own choices: the address map and the strobed register port.
// Functional notes
// - Code 0x01 single: erase one block
// - Plane-parallel erase walks consecutive plane blocks
// - Erase done only after last block
// - Erase failure flags error, records block
// - Lock codes ignored without lock support
// - Unlock span: start 0x10, end 0x11
// - Code 0x21 locks all, address ignored
// - Code 0x31 lock-tight; only reset clears
// - Lock-tight refuses every lock change
// - Mode codes 0x41, 0x42, 0x43 select transfer
// - Selected mode holds until next mode
// - Code 0x60 loads page into buffer
// - Code 0x61 starts program with destination
// - Code 0x62 commits and completes program
// - Load done and write done events
// - No error-correction use during read-modify-write
// - Program failure flags error, records block, page
module nsf_sequencer
  import nsf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output nsf_flash_req_type fl_req,
  input  nsf_flash_rsp_type fl_rsp,
  output nsf_mode_type     xfer_mode,
  output nsf_event_type    events,
  output logic             busy
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    nsf_state_type     st;       // Sequencer state
    logic              armed;    // Command word waiting for data
    nsf_addr_type      addr;     // Latched address
    nsf_op_type        op;       // Operation in flight
    nsf_addr_type      oaddr;    // Address of the operation in flight
    logic [BLK_W-1:0]  unlk_lo;  // Unlock span start
    logic [BLK_W-1:0]  unlk_hi;  // Unlock span end
    logic              unlk_ok;  // Span start present
    logic              tight;    // Lock-tight in force
    nsf_mode_type      mode;     // Current transfer mode
    logic [31:0]       cfg;      // Configuration word
    logic [BLK_W-1:0]  fblk;     // Failing block record
    logic [PAGE_W-1:0] fpage;    // Failing page record
    logic [31:0]       rdata;    // Read data
    nsf_flash_req_type req;      // Flash request
    nsf_event_type     ev;       // Event pulses
  } nsf_main_type;

  nsf_main_type q, d;

  nsf_func_type     func;       // Decoded code of the data write
  logic             data_go;    // Data write accepted
  logic             pw_start;   // Begin a plane walk
  logic             pw_adv;     // Step to the next plane
  logic [BLK_W-1:0] pw_cur;     // Block being erased
  logic             pw_last;    // Last plane of the walk
  logic [PLANES_W-1:0] pw_cnt;  // Blocks in this erase

  ////////////////////////////////////////////////////////////////////////
  // Submodules

  nsf_func_decode u_dec (
    .code (reg_wdata[7:0]),
    .func (func)
  );

  nsf_plane_walk #(
    .CNT_W (PLANES_W)
  ) u_walk (
    .core_clk (core_clk),
    .rstn     (rstn),
    .start    (pw_start),
    .adv      (pw_adv),
    .base     (q.addr.block),
    .count    (pw_cnt),
    .cur      (pw_cur),
    .last     (pw_last)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Data write only acts on an armed command while idle
  assign data_go = reg_wr && (reg_addr == OFF_DATA) && q.armed && (q.st == S_IDLE);

  always_comb begin
    d          = q;
    d.req      = '0;
    d.ev       = '0;
    d.rdata    = '0;
    pw_start   = 1'b0;
    pw_adv     = 1'b0;
    // Plane count only under plane-parallel mode
    pw_cnt     = q.cfg[CFG_PLANE_PAR] ? q.cfg[CFG_PLANES_LSB +: PLANES_W]
                                      : PLANES_W'(1);

    // Register reads, answered next cycle
    if (reg_rd) begin
      case (reg_addr)
        OFF_CMD:   d.rdata = {8'h00, q.addr};
        OFF_CFG:   d.rdata = q.cfg;
        OFF_STAT:  d.rdata = {26'h0, q.unlk_ok, q.armed, q.tight, q.mode,
                              (q.st != S_IDLE)};
        OFF_FBLK:  d.rdata = {{(32-BLK_W){1'b0}}, q.fblk};
        OFF_FPAGE: d.rdata = {{(32-PAGE_W){1'b0}}, q.fpage};
        default:   d.rdata = '0;
      endcase
    end

    // Command word: only the special class arms
    if (reg_wr && reg_addr == OFF_CMD) begin
      d.armed = (reg_wdata[CMD_CLASS_LSB +: 2] == CLASS_SPECIAL);
      d.addr  = reg_wdata[ADDR_W-1:0];
    end

    // Configuration word
    if (reg_wr && reg_addr == OFF_CFG) begin
      d.cfg = reg_wdata;
    end

    case (q.st)
      // Execute the function of the data write
      S_IDLE: begin
        if (data_go) begin
          d.armed = 1'b0;
          case (func)
            F_ERASE: begin
              pw_start = 1'b1;
              d.op     = OP_ERASE;
              d.st     = S_ISSUE;
            end
            F_UNLK_LO: begin
              if (q.cfg[CFG_LOCK_OK] && !q.tight) begin
                d.unlk_lo = q.addr.block;
                d.unlk_ok = 1'b1;
              end
            end
            F_UNLK_HI: begin
              if (q.cfg[CFG_LOCK_OK] && !q.tight && q.unlk_ok) begin
                d.unlk_hi = q.addr.block;
                d.unlk_ok = 1'b0;
                d.op      = OP_UNLOCK;
                d.st      = S_ISSUE;
              end
            end
            F_LOCK: begin
              if (q.cfg[CFG_LOCK_OK] && !q.tight) begin
                d.addr = '0;
                d.op   = OP_LOCK_ALL;
                d.st   = S_ISSUE;
              end
            end
            F_TIGHT: begin
              if (q.cfg[CFG_LOCK_OK] && !q.tight) begin
                d.addr  = '0;
                d.tight = 1'b1;
                d.op    = OP_LOCK_TIGHT;
                d.st    = S_ISSUE;
              end
            end
            F_SPARE:   d.mode = XM_SPARE;
            F_DEFAULT: d.mode = q.cfg[CFG_SPARE_DEF] ? XM_BOTH : XM_MAIN;
            F_BOTH:    d.mode = XM_BOTH;
            F_LOAD: begin
              d.op = OP_LOAD;
              d.st = S_ISSUE;
            end
            F_DEST: begin
              d.op = OP_PROG_START;
              d.st = S_ISSUE;
            end
            F_COMMIT: begin
              d.op = OP_PROG_COMMIT;
              d.st = S_ISSUE;
            end
            default: d.op = OP_NONE;
          endcase
        end
      end

      // One-cycle request to the flash engine
      S_ISSUE: begin
        d.req.valid    = 1'b1;
        d.req.op       = q.op;
        d.req.addr     = q.addr;
        d.req.addr_end = q.unlk_hi;
        d.req.ecc_use  = 1'b0;
        // Keep the issued address; a later command word may overwrite q.addr
        d.oaddr        = q.addr;
        if (q.op == OP_ERASE) begin
          d.req.addr.block = pw_cur;
        end else if (q.op == OP_UNLOCK) begin
          d.req.addr.block = q.unlk_lo;
        end
        d.st = S_WAIT;
      end

      // Wait for the flash to finish
      S_WAIT: begin
        if (fl_rsp.done) begin
          d.st = S_IDLE;
          case (q.op)
            OP_ERASE: begin
              if (fl_rsp.fail) begin
                d.ev.erase_err = 1'b1;
                d.fblk         = pw_cur;
              end
              if (pw_last) begin
                d.ev.erase_done = 1'b1;
              end else begin
                pw_adv = 1'b1;
                d.st   = S_ISSUE;
              end
            end
            OP_LOAD: d.ev.load_done = 1'b1;
            OP_PROG_COMMIT: begin
              if (fl_rsp.fail) begin
                d.ev.write_err = 1'b1;
                d.fblk         = q.oaddr.block;
                d.fpage        = q.oaddr.page;
              end else begin
                d.ev.write_done = 1'b1;
              end
            end
            default: d.op = q.op;
          endcase
        end
      end

      default: d.st = S_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State register; lock-tight leaves only through reset

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q      <= '0;
      q.cfg  <= CFG_RST;
      q.mode <= XM_MAIN;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign fl_req    = q.req;
  assign xfer_mode = q.mode;
  assign events    = q.ev;
  assign busy      = (q.st != S_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_lock_code;
    data_go && (func inside {F_UNLK_HI, F_LOCK, F_TIGHT});
  endsequence

  sequence s_erase_code;
    data_go && (func == F_ERASE);
  endsequence

  a_exec_on_data: assert property (s_erase_code |-> ##2 (fl_req.valid && fl_req.op == OP_ERASE))
    else $error("erase request not issued two cycles after data write");

  a_lock_unsupported: assert property ((s_lock_code and !q.cfg[CFG_LOCK_OK]) |=> !fl_req.valid [*3])
    else $error("lock request issued without lock support");

  a_tight_refuse: assert property ((s_lock_code and q.tight) |=> !fl_req.valid [*3])
    else $error("lock change issued under lock-tight");

  a_tight_held: assert property (q.tight |=> q.tight)
    else $error("lock-tight dropped without reset");

  a_lock_all_addr: assert property (fl_req.valid && fl_req.op inside {OP_LOCK_ALL, OP_LOCK_TIGHT} |-> fl_req.addr == '0)
    else $error("lock-all request carries an address");

  a_erase_done_last: assert property (events.erase_done |-> $past(fl_rsp.done && pw_last && q.op == OP_ERASE))
    else $error("erase done before the last plane");

  a_erase_err_rec: assert property (fl_rsp.done && fl_rsp.fail && q.st == S_WAIT && q.op == OP_ERASE |=> events.erase_err && q.fblk == $past(pw_cur))
    else $error("erase failure not reported with its block");

  a_mode_select: assert property (data_go && func == F_SPARE |=> xfer_mode == XM_SPARE ##1 xfer_mode == XM_SPARE)
    else $error("spare mode not selected");

  a_write_err_rec: assert property (events.write_err |-> q.fpage == $past(q.oaddr.page) && q.fblk == $past(q.oaddr.block))
    else $error("program failure recorded wrongly");

  a_rmw_no_ecc: assert property (fl_req.valid && fl_req.op inside {OP_LOAD, OP_PROG_START, OP_PROG_COMMIT} |-> !fl_req.ecc_use)
    else $error("error correction requested during read-modify-write");

endmodule : nsf_sequencer

// ---- nsf_pkg.sv ----
/*
  Shared constants and types for the NAND special-function sequencer.
  Assumes a single core clock and a flash engine that executes one
  primitive operation per request and answers with a done pulse.
*/
package nsf_pkg;

  // Address split of the command word
  localparam int BLK_W  = 18;
  localparam int PAGE_W = 6;
  localparam int ADDR_W = BLK_W + PAGE_W;

  // Register offsets
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_DATA  = 8'h04;
  localparam logic [7:0] OFF_CFG   = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0C;
  localparam logic [7:0] OFF_FBLK  = 8'h10;
  localparam logic [7:0] OFF_FPAGE = 8'h14;

  // Command word: class selector above the address
  localparam int         CMD_CLASS_LSB = 24;
  localparam logic [1:0] CLASS_SPECIAL = 2'h2;

  // Configuration fields and reset value
  localparam int          CFG_PLANE_PAR  = 0;
  localparam int          CFG_SPARE_DEF  = 1;
  localparam int          CFG_LOCK_OK    = 2;
  localparam int          CFG_PLANES_LSB = 4;
  localparam int          PLANES_W       = 4;
  localparam logic [31:0] CFG_RST        = 32'h0000_0014;

  // Function codes carried by the data write
  localparam logic [7:0] FC_ERASE    = 8'h01;
  localparam logic [7:0] FC_UNLK_LO  = 8'h10;
  localparam logic [7:0] FC_UNLK_HI  = 8'h11;
  localparam logic [7:0] FC_LOCK     = 8'h21;
  localparam logic [7:0] FC_TIGHT    = 8'h31;
  localparam logic [7:0] FC_SPARE    = 8'h41;
  localparam logic [7:0] FC_DEFAULT  = 8'h42;
  localparam logic [7:0] FC_BOTH     = 8'h43;
  localparam logic [7:0] FC_LOAD     = 8'h60;
  localparam logic [7:0] FC_DEST     = 8'h61;
  localparam logic [7:0] FC_COMMIT   = 8'h62;

  // Decoded special functions
  typedef enum logic [3:0] {
    F_NONE = 4'h0, F_ERASE = 4'h1, F_UNLK_LO = 4'h2, F_UNLK_HI = 4'h3,
    F_LOCK = 4'h4, F_TIGHT = 4'h5, F_SPARE = 4'h6, F_DEFAULT = 4'h7,
    F_BOTH = 4'h8, F_LOAD = 4'h9, F_DEST = 4'hA, F_COMMIT = 4'hB
  } nsf_func_type;

  // Primitive operations sent to the flash engine
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_ERASE = 3'h1, OP_UNLOCK = 3'h2, OP_LOCK_ALL = 3'h3,
    OP_LOCK_TIGHT = 3'h4, OP_LOAD = 3'h5, OP_PROG_START = 3'h6,
    OP_PROG_COMMIT = 3'h7
  } nsf_op_type;

  // Transfer modes for later data commands
  typedef enum logic [1:0] {
    XM_MAIN = 2'h0, XM_SPARE = 2'h1, XM_BOTH = 2'h2
  } nsf_mode_type;

  // Sequencer states
  typedef enum logic [1:0] {
    S_IDLE = 2'h0, S_ISSUE = 2'h1, S_WAIT = 2'h2
  } nsf_state_type;

  typedef struct packed {
    logic [BLK_W-1:0]  block;
    logic [PAGE_W-1:0] page;
  } nsf_addr_type;

  typedef struct packed {
    logic             valid;
    nsf_op_type       op;
    nsf_addr_type     addr;
    logic [BLK_W-1:0] addr_end;
    logic             ecc_use;
  } nsf_flash_req_type;

  typedef struct packed {
    logic done;
    logic fail;
  } nsf_flash_rsp_type;

  typedef struct packed {
    logic erase_done;
    logic erase_err;
    logic load_done;
    logic write_done;
    logic write_err;
  } nsf_event_type;

endpackage : nsf_pkg

// ---- nsf_func_decode.sv ----
/*
  Maps a data-register function code onto a special function.
  Purely combinational; unknown codes map to F_NONE.
*/
module nsf_func_decode
  import nsf_pkg::*;
(
  input  wire logic [7:0]   code,
  output nsf_func_type      func
);

  // Code table
  always_comb begin
    case (code)
      FC_ERASE:   func = F_ERASE;
      FC_UNLK_LO: func = F_UNLK_LO;
      FC_UNLK_HI: func = F_UNLK_HI;
      FC_LOCK:    func = F_LOCK;
      FC_TIGHT:   func = F_TIGHT;
      FC_SPARE:   func = F_SPARE;
      FC_DEFAULT: func = F_DEFAULT;
      FC_BOTH:    func = F_BOTH;
      FC_LOAD:    func = F_LOAD;
      FC_DEST:    func = F_DEST;
      FC_COMMIT:  func = F_COMMIT;
      default:    func = F_NONE;
    endcase
  end

endmodule : nsf_func_decode

// ---- nsf_plane_walk.sv ----
/*
  Walks consecutive blocks of a multi-plane erase.
  Assumes start and adv are single-cycle pulses and never coincide.
*/
module nsf_plane_walk
  import nsf_pkg::*;
#(
  parameter int CNT_W = PLANES_W
)(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire logic             adv,
  input  wire logic [BLK_W-1:0] base,
  input  wire logic [CNT_W-1:0] count,
  output logic      [BLK_W-1:0] cur,
  output logic                  last
);

  // Refuse a counter that cannot hold one plane
  if (CNT_W < 1) begin : g_chk
    $error("nsf_plane_walk: CNT_W must be at least 1");
  end

  typedef struct packed {
    logic [BLK_W-1:0] blk;   // Block being erased
    logic [CNT_W-1:0] left;  // Blocks left including this one
  } nsf_walk_type;

  nsf_walk_type q, d;

  // Next block and remaining count
  always_comb begin
    d = q;
    if (start) begin
      d.blk  = base;
      d.left = (count == '0) ? CNT_W'(1) : count;
    end else if (adv) begin
      d.blk  = q.blk + BLK_W'(1);
      d.left = q.left - CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cur  = q.blk;
  assign last = (q.left <= CNT_W'(1));

endmodule : nsf_plane_walk

// ---- nsf_flash_model.sv ----
/*
  Behavioural flash engine facing the special-function sequencer.
  Assumes one request at a time and a latency and fail target set by
  the bench between operations.
*/
module nsf_flash_model
  import nsf_pkg::*;
(
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  nsf_flash_req_type     fl_req,
  input  wire logic [3:0]       lat,
  input  wire logic             fail_en,
  input  wire logic [BLK_W-1:0] fail_blk,
  output nsf_flash_rsp_type     fl_rsp
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt_q; // Cycles left, zero when idle
  logic       bad_q; // Outcome of the running operation

  // Count down the latency, then one done pulse
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= '0;
      bad_q  <= 1'b0;
      fl_rsp <= '0;
    end else begin
      fl_rsp.done <= 1'b0;
      // Fail means nothing outside done, so it keeps changing
      fl_rsp.fail <= ~fl_rsp.fail;
      if (fl_req.valid) begin
        cnt_q <= {1'b0, lat} + 5'h01;
        bad_q <= fail_en && (fl_req.addr.block == fail_blk);
      end else if (cnt_q == 5'h01) begin
        fl_rsp <= {1'b1, bad_q};
        cnt_q  <= '0;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule : nsf_flash_model

// ---- testbench.sv ----
/*
  Self-checking bench for the special-function sequencer.
  Assumes the flash model file and the design package are compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import nsf_pkg::*;
  logic              core_clk, rstn, reg_wr, reg_rd, busy, fail_en;
  logic [7:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [3:0]        lat;
  logic [BLK_W-1:0]  fail_blk;
  nsf_flash_req_type fl_req, last_req;
  nsf_flash_rsp_type fl_rsp;
  nsf_mode_type      xfer_mode;
  nsf_event_type     events;
  logic [3:0]        ev[5];       // Event pulse counts
  nsf_flash_req_type q[$];        // Seen flash requests
  int                num_errors, checks;

  nsf_sequencer uut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fl_req(fl_req), .fl_rsp(fl_rsp), .xfer_mode(xfer_mode), .events(events),
    .busy(busy));
  nsf_flash_model flash (.core_clk(core_clk), .rstn(rstn), .fl_req(fl_req),
    .lat(lat), .fail_en(fail_en), .fail_blk(fail_blk), .fl_rsp(fl_rsp));

  ////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Record requests and event pulses
  always @(posedge core_clk) begin
    if (fl_req.valid === 1'b1) q.push_back(fl_req);
    for (int i = 0; i < 5; i++) if (events[i] === 1'b1) ev[i] <= ev[i] + 4'h1;
  end

  ////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task do_reset;
    @(posedge core_clk);
    rstn <= 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    q.delete();
    ev = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  endtask : do_reset

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd

  // Bounded wait for the sequencer to go idle, then let events land
  task idle;
    int n;
    repeat (3) @(posedge core_clk);
    #1 n = 0;
    while (busy !== 1'b0 && n < 300) begin
      @(posedge core_clk);
      #1 n++;
    end
    if (n >= 300) begin
      num_errors++;
      end_of_test();
    end
    repeat (2) @(posedge core_clk);
  endtask : idle

  // Command write of class two, then the function code
  task sf(input logic [BLK_W-1:0] b, input logic [PAGE_W-1:0] p, input logic [7:0] c);
    wr(OFF_CMD, {6'h00, CLASS_SPECIAL, b, p});
    wr(OFF_DATA, {24'h000000, c});
    idle();
  endtask : sf

  task chk_req(input nsf_op_type op, input logic [BLK_W-1:0] b, input logic [PAGE_W-1:0] p);
    last_req = '0;
    if (q.size() != 0) last_req = q.pop_front();
    chk(32'({last_req.ecc_use, last_req.op, last_req.addr}), 32'({1'b0, op, b, p}));
  endtask : chk_req

  // One hex digit per event, erase_done highest
  task chk_ev(input logic [19:0] e);
    chk(32'({ev[4], ev[3], ev[2], ev[1], ev[0]}), 32'(e));
    ev = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  endtask : chk_ev

  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00;
    reg_wdata = 32'h0; lat = 4'h4; fail_en = 1'b0; fail_blk = '0;
    num_errors = 0; checks = 0;
    do_reset();
    rd(OFF_CFG, 32'h14);
    rd(OFF_STAT, 32'h0);
    rd(8'h20, 32'h0);
    rd(OFF_DATA, 32'h0);
    $display("test reset done");
    // Modes change only between transfers here
    for (int s = 0; s < 2; s++) begin
      wr(OFF_CFG, s ? 32'h16 : 32'h14);
      sf('0, '0, FC_SPARE);
      chk(32'(xfer_mode), 32'h1);
      sf('0, '0, FC_DEFAULT);
      chk(32'(xfer_mode), s ? 32'h2 : 32'h0);
      sf('0, '0, FC_BOTH);
      chk(32'(xfer_mode), 32'h2);
    end
    wr(OFF_CFG, 32'h14);
    chk(32'(xfer_mode), 32'h2);
    chk(32'(q.size()), 32'h0);
    $display("test mode done");
    wr(OFF_DATA, 32'(FC_ERASE));
    wr(OFF_CMD, {6'h00, 2'h1, 18'h00005, 6'h00});
    wr(OFF_DATA, 32'(FC_ERASE));
    wr(OFF_CMD, {6'h00, CLASS_SPECIAL, 18'h00005, 6'h00});
    repeat (4) @(posedge core_clk);
    chk(32'(q.size()), 32'h0);
    wr(OFF_DATA, 32'(FC_ERASE));
    #1 chk(32'(busy), 32'h1);
    idle();
    chk_req(OP_ERASE, 18'h00005, 6'h00);
    chk_ev(20'h10000);
    rd(OFF_CMD, 32'h140);
    wr(OFF_DATA, 32'(FC_ERASE));
    idle();
    chk(32'(q.size()), 32'h0);
    $display("test erase done");
    lat <= 4'h9;
    fail_en <= 1'b1;
    fail_blk <= 18'h00009;
    wr(OFF_CFG, 32'h25);
    sf(18'h00008, 6'h01, FC_ERASE);
    chk_req(OP_ERASE, 18'h00008, 6'h01);
    chk_req(OP_ERASE, 18'h00009, 6'h01);
    chk(32'(q.size()), 32'h0);
    chk_ev(20'h11000);
    rd(OFF_FBLK, 32'h9);
    fail_en <= 1'b0;
    $display("test planes done");
    wr(OFF_CFG, 32'h10);
    sf(18'h00003, '0, FC_UNLK_LO);
    sf(18'h00007, '0, FC_UNLK_HI);
    sf(18'h00001, '0, FC_LOCK);
    sf(18'h00001, '0, FC_TIGHT);
    chk(32'(q.size()), 32'h0);
    rd(OFF_STAT, 32'h4);
    wr(OFF_CFG, 32'h14);
    sf(18'h00003, '0, FC_UNLK_LO);
    sf(18'h00007, '0, FC_UNLK_HI);
    chk_req(OP_UNLOCK, 18'h00003, 6'h00);
    chk(32'(last_req.addr_end), 32'h7);
    sf(18'h00055, '0, FC_LOCK);
    chk_req(OP_LOCK_ALL, '0, '0);
    sf(18'h00005, '0, FC_TIGHT);
    chk_req(OP_LOCK_TIGHT, '0, '0);
    rd(OFF_STAT, 32'hC);
    sf(18'h00002, '0, FC_LOCK);
    sf(18'h00002, '0, FC_UNLK_LO);
    sf(18'h00004, '0, FC_UNLK_HI);
    chk(32'(q.size()), 32'h0);
    do_reset();
    rd(OFF_STAT, 32'h0);
    $display("test lock done");
    lat <= 4'h2;
    sf(18'h00002, 6'h03, FC_LOAD);
    chk_req(OP_LOAD, 18'h00002, 6'h03);
    chk_ev(20'h00100);
    sf(18'h00004, 6'h05, FC_DEST);
    chk_req(OP_PROG_START, 18'h00004, 6'h05);
    chk_ev(20'h00000);
    sf(18'h00004, 6'h05, FC_COMMIT);
    chk_req(OP_PROG_COMMIT, 18'h00004, 6'h05);
    chk_ev(20'h00010);
    fail_en <= 1'b1;
    fail_blk <= 18'h00004;
    sf(18'h00004, 6'h05, FC_DEST);
    // New command word lands while the commit is in flight
    wr(OFF_CMD, {6'h00, CLASS_SPECIAL, 18'h00004, 6'h05});
    wr(OFF_DATA, {24'h000000, FC_COMMIT});
    wr(OFF_CMD, {6'h00, CLASS_SPECIAL, 18'h0003F, 6'h2A});
    idle();
    chk_req(OP_PROG_START, 18'h00004, 6'h05);
    chk_req(OP_PROG_COMMIT, 18'h00004, 6'h05);
    chk_ev(20'h00001);
    rd(OFF_FBLK, 32'h4);
    rd(OFF_FPAGE, 32'h5);
    $display("test rmw done");
    end_of_test();
  end
endmodule : testbench
